// *** buck_peak_voltage_pin_ctrl.sv ***
// Buck channel peak-current, output-voltage and pin-enable configuration.
// Assumes a synchronous register write/read port and synchronous pins.
//
// Summary of operation
// RULE1 - Bypass bit picks programmed code over table
// RULE2 - Peak code decodes in 25mA steps
// RULE3 - Programmed code ignored while bypass clear
// RULE4 - Host keeps code near 150-200mA
// RULE5 - Voltage is 0.50V plus code times step
// RULE6 - Mask bit n selects control pin n
// RULE7 - Selected pins combine by logical OR
// RULE8 - Mask only valid when sequencing 111, mode 10
// RULE9 - Adaptive disable holds peak current fixed
// RULE10 - No pin selected keeps regulator off
`default_nettype none

// ******************************************************************
// Configuration byte
// ******************************************************************

// One register of the bank; bits outside the keep mask are never stored
module buck_cfg_reg
  import buck_pkg::*;
#(
  parameter logic [7:0] ADDR      = 8'h00,
  parameter logic [7:0] RST_VALUE = 8'h00,
  parameter logic [7:0] KEEP_MASK = 8'hFF
) (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire reg_req_t   i_req,
  output logic            o_selected,
  output logic      [7:0] o_value
);

  logic [7:0] value_reg;
  logic [7:0] value_next;

  wire logic addr_match = (i_req.addr == ADDR);
  wire logic write_hit  = i_req.wr && addr_match;

  // Reserved bits are dropped here, so they always read back as zero
  assign value_next = write_hit ? (i_req.wdata & KEEP_MASK) : value_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      value_reg <= RST_VALUE & KEEP_MASK;
    end else begin
      value_reg <= value_next;
    end
  end

  assign o_selected = addr_match;
  assign o_value    = value_reg;

endmodule : buck_cfg_reg

// ******************************************************************
// Channel configuration
// ******************************************************************

module buck_peak_voltage_pin_ctrl
  import buck_pkg::*;
#(
  parameter logic [9:0] STEP_MV = 10'h00A
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire reg_req_t    i_req,
  input  wire logic [7:0]  i_pins,
  input  wire logic [2:0]  i_sequencing_select,
  input  wire logic [1:0]  i_enable_mode_field,
  input  wire logic        i_adaptive_peak_disable,
  input  wire logic [3:0]  i_table_peak_code,
  output logic      [7:0]  o_rdata,
  output logic      [3:0]  o_peak_code,
  output logic      [9:0]  o_peak_ma,
  output logic             o_peak_adaptive,
  output logic      [11:0] o_vout_mv,
  output logic             o_pin_enable,
  output logic             o_pin_mode
);

  // ******************************************************************
  // Register bank
  // ******************************************************************

  logic [7:0] peak_cfg;
  logic [7:0] vout_cfg;
  logic [7:0] pin_cfg;
  logic       peak_sel;
  logic       vout_sel;
  logic       pin_sel;

  buck_cfg_reg #(
    .ADDR      (ADDR_PEAK_CFG),
    .RST_VALUE (RST_PEAK_CFG),
    .KEEP_MASK (PEAK_CFG_MASK)
  ) u_peak_cfg (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_req      (i_req),
    .o_selected (peak_sel),
    .o_value    (peak_cfg)
  );

  buck_cfg_reg #(
    .ADDR      (ADDR_VOUT_CFG),
    .RST_VALUE (RST_VOUT_CFG),
    .KEEP_MASK (VOUT_CFG_MASK)
  ) u_vout_cfg (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_req      (i_req),
    .o_selected (vout_sel),
    .o_value    (vout_cfg)
  );

  buck_cfg_reg #(
    .ADDR      (ADDR_PIN_SEL),
    .RST_VALUE (RST_PIN_SEL),
    .KEEP_MASK (8'hFF)
  ) u_pin_cfg (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_req      (i_req),
    .o_selected (pin_sel),
    .o_value    (pin_cfg)
  );

  // Addresses are distinct, so at most one term is non-zero;
  // an unmapped address reads as zero
  wire logic [7:0] peak_rd = peak_sel ? peak_cfg : 8'h00;
  wire logic [7:0] vout_rd = vout_sel ? vout_cfg : 8'h00;
  wire logic [7:0] pin_rd  = pin_sel  ? pin_cfg  : 8'h00;

  assign o_rdata = peak_rd | vout_rd | pin_rd;

  // ******************************************************************
  // Peak current decode
  // ******************************************************************

  wire logic        bypass    = peak_cfg[BYPASS_BIT];
  wire logic [3:0]  prog_code = peak_cfg[CODE_MSB:0];
  // While bypass is clear the stored code is simply not selected
  wire logic [3:0]  sel_code  = bypass ? prog_code          // RULE1 RULE3
                                       : i_table_peak_code; // RULE1
  wire logic [19:0] peak_prod = PEAK_STEP_MA * {6'h00, sel_code}; // RULE2
  // Top code gives 375 mA, so ten bits never wrap
  wire logic [9:0]  peak_ma   = peak_prod[9:0];

  // ******************************************************************
  // Output voltage decode
  // ******************************************************************

  wire logic [5:0]  vcode     = vout_cfg[VCODE_MSB:0];
  wire logic [19:0] vout_step = STEP_MV * {4'h0, vcode};
  wire logic [19:0] vout_sum  = {10'h000, VOUT_BASE_MV} + vout_step; // RULE5
  // Twelve bits hold the sum for any step up to 57 mV
  wire logic [11:0] vout_mv   = vout_sum[11:0];

  // ******************************************************************
  // Pin enable
  // ******************************************************************

  wire logic [7:0] pins_chosen = i_pins & pin_cfg;        // RULE6
  // An empty mask ORs to zero, which keeps the regulator off
  wire logic       pins_any    = |pins_chosen;            // RULE7 RULE10
  wire logic       seq_match   = (i_sequencing_select == SEQ_PIN_CTRL);
  wire logic       mode_match  = (i_enable_mode_field == EN_MODE_PIN);
  wire logic       pin_mode    = seq_match && mode_match; // RULE8
  // Outside pin mode the mask stays stored but has no effect
  wire logic       pin_enable  = pin_mode && pins_any;    // RULE8

  // ******************************************************************
  // Output registers
  // ******************************************************************

  // Every output except o_rdata lags its pin inputs by one edge and a register write by two
  logic [3:0]  peak_code_reg;
  logic [3:0]  peak_code_next;
  logic [9:0]  peak_ma_reg;
  logic [9:0]  peak_ma_next;
  logic        adaptive_reg;
  logic        adaptive_next;
  logic [11:0] vout_mv_reg;
  logic [11:0] vout_mv_next;
  logic        pin_enable_reg;
  logic        pin_enable_next;
  logic        pin_mode_reg;
  logic        pin_mode_next;

  assign peak_code_next  = sel_code;
  assign peak_ma_next    = peak_ma;
  assign adaptive_next   = !i_adaptive_peak_disable;    // RULE9

  assign vout_mv_next    = vout_mv;

  assign pin_enable_next = pin_enable;
  assign pin_mode_next   = pin_mode;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      peak_code_reg  <= 4'h0;
      peak_ma_reg    <= 10'h000;
      adaptive_reg   <= RST_PEAK_ADAPT;
      vout_mv_reg    <= 12'h000;
      pin_enable_reg <= 1'h0;
      pin_mode_reg   <= 1'h0;
    end else begin
      peak_code_reg  <= peak_code_next;
      peak_ma_reg    <= peak_ma_next;
      adaptive_reg   <= adaptive_next;
      vout_mv_reg    <= vout_mv_next;
      pin_enable_reg <= pin_enable_next;
      pin_mode_reg   <= pin_mode_next;
    end
  end

  assign o_peak_code     = peak_code_reg;
  assign o_peak_ma       = peak_ma_reg;
  assign o_peak_adaptive = adaptive_reg;
  assign o_vout_mv       = vout_mv_reg;
  assign o_pin_enable    = pin_enable_reg;
  assign o_pin_mode      = pin_mode_reg;

endmodule : buck_peak_voltage_pin_ctrl

`default_nettype wire

// *** buck_pkg.sv ***
// Package for the buck channel configuration bank.
// Assumes an internal register port decoded by the device's serial block.
`default_nettype none

package buck_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [7:0] ADDR_PEAK_CFG  = 8'h33;
  localparam logic [7:0] ADDR_VOUT_CFG  = 8'h34;
  localparam logic [7:0] ADDR_PIN_SEL   = 8'h35;

  localparam logic [7:0] RST_PEAK_CFG   = 8'h00;
  localparam logic [7:0] RST_VOUT_CFG   = 8'h00;
  localparam logic [7:0] RST_PIN_SEL    = 8'h00;
  localparam logic       RST_PEAK_ADAPT = 1'h1;

  localparam int         BYPASS_BIT     = 7;
  localparam int         CODE_MSB       = 3;
  localparam int         VCODE_MSB      = 5;
  localparam logic [7:0] PEAK_CFG_MASK  = 8'h8F;
  localparam logic [7:0] VOUT_CFG_MASK  = 8'h3F;

  // ******************************************************************
  // Decode constants
  // ******************************************************************
  localparam logic [9:0] PEAK_STEP_MA   = 10'h019;
  localparam logic [9:0] VOUT_BASE_MV   = 10'h1F4;
  localparam logic [2:0] SEQ_PIN_CTRL   = 3'h7;
  localparam logic [1:0] EN_MODE_PIN    = 2'h2;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : buck_pkg

`default_nettype wire

// *** buck_chk.sv ***
// Checker: port relations of the buck bank, bound to its top module below.
`default_nettype none
module buck_chk
  import buck_pkg::*;
#(
  parameter logic [9:0] STEP_MV = 10'h00A
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire reg_req_t    i_req,
  input  wire logic [7:0]  i_pins,
  input  wire logic [2:0]  i_sequencing_select,
  input  wire logic [1:0]  i_enable_mode_field,
  input  wire logic        i_adaptive_peak_disable,
  input  wire logic [3:0]  i_table_peak_code,
  input  wire logic [7:0]  o_rdata,
  input  wire logic [3:0]  o_peak_code,
  input  wire logic [9:0]  o_peak_ma,
  input  wire logic        o_peak_adaptive,
  input  wire logic [11:0] o_vout_mv,
  input  wire logic        o_pin_enable,
  input  wire logic        o_pin_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire logic s = i_sequencing_select == 3'h7 && i_enable_mode_field == 2'h2;
  wire logic [7:0] a = i_req.addr;
  property p_ma; o_peak_ma == o_peak_code * 10'h019; endproperty
  a_ma: assert property (p_ma) else $error("peak mA");
  property p_tb; a == 8'h33 && !o_rdata[7] |=>
    o_peak_code == $past(i_table_peak_code); endproperty
  a_tb: assert property (p_tb) else $error("table");
  property p_by; a == 8'h33 && o_rdata[7] |=>
    o_peak_code == 4'($past(o_rdata)); endproperty
  a_by: assert property (p_by) else $error("bypass");
  property p_ad; 1 |=> o_peak_adaptive == !$past(i_adaptive_peak_disable);
  endproperty
  a_ad: assert property (p_ad) else $error("adaptive");
  property p_vo; a == 8'h34 |=>
    o_vout_mv == 12'h1F4 + 12'($past(o_rdata)) * 12'(STEP_MV); endproperty
  a_vo: assert property (p_vo) else $error("vout");
  property p_pn; s && a == 8'h35 |=>
    o_pin_enable == |($past(o_rdata) & $past(i_pins)); endproperty
  a_pn: assert property (p_pn) else $error("pin");
  property p_of; !s |=> !o_pin_enable && !o_pin_mode; endproperty
  a_of: assert property (p_of) else $error("off");
  property p_md; s |=> o_pin_mode; endproperty
  a_md: assert property (p_md) else $error("mode");
  cover property (o_pin_enable);
  cover property (o_peak_ma == 10'h177);
  cover property (o_vout_mv == 12'h46A);
endmodule : buck_chk
bind buck_peak_voltage_pin_ctrl buck_chk #(
  .STEP_MV(STEP_MV)
) u_chk (
  .i_clk                   (i_clk),
  .i_rstn                  (i_rstn),
  .i_req                   (i_req),
  .i_pins                  (i_pins),
  .i_sequencing_select     (i_sequencing_select),
  .i_enable_mode_field     (i_enable_mode_field),
  .i_adaptive_peak_disable (i_adaptive_peak_disable),
  .i_table_peak_code       (i_table_peak_code),
  .o_rdata                 (o_rdata),
  .o_peak_code             (o_peak_code),
  .o_peak_ma               (o_peak_ma),
  .o_peak_adaptive         (o_peak_adaptive),
  .o_vout_mv               (o_vout_mv),
  .o_pin_enable            (o_pin_enable),
  .o_pin_mode              (o_pin_mode)
);
`default_nettype wire

// *** host_model.sv ***
// Host model: register writes; address left set so reads follow it.
`default_nettype none
module host_model import buck_pkg::*; (
  input wire logic     i_clk,
  output var reg_req_t o_req = '0);
  timeunit 1ns;
  timeprecision 1ns;
  // Any code written; tuning near 150-200mA is the host's own choice
  task automatic wr(logic [7:0] a, v);
    @(posedge i_clk);
    #1 o_req = '{1'b1, a, v};
    @(posedge i_clk);
    #1 o_req.wr = 1'b0;
  endtask : wr
endmodule : host_model
`default_nettype wire

// *** testbench.sv ***
// Bench: corner codes, then random writes and pins; assumes host_model.
`default_nettype none
module testbench import buck_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, adis = 0;
  logic [7:0] pins = 0, a, d, sh [8] = '{default: 0};
  logic [4:0] md = 0;
  logic [3:0] tbl = 0;
  logic [31:0] r;
  wire logic [7:0] rd;
  wire logic [28:0] q;
  wire reg_req_t req;
  int errors = 0, compares = 0, seed = 41836;
  buck_peak_voltage_pin_ctrl u_dut (.i_clk(clk), .i_rstn(rstn), .i_req(req),
    .i_pins(pins), .i_sequencing_select(md[4:2]), .o_rdata(rd),
    .i_enable_mode_field(md[1:0]), .i_adaptive_peak_disable(adis),
    .i_table_peak_code(tbl), .o_peak_code(q[28:25]), .o_peak_ma(q[24:15]),
    .o_peak_adaptive(q[14]), .o_vout_mv(q[13:2]), .o_pin_enable(q[1]),
    .o_pin_mode(q[0]));
  host_model u_host (.i_clk(clk), .o_req(req));
  task automatic chk(string n, logic [28:0] e, g);
    compares++;
    if (e !== g) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic test_done;
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  function automatic logic [28:0] exp_out;
    logic [3:0] c = sh[3][7] ? sh[3][3:0] : tbl;
    return {c, 10'(c) * 10'h019, !adis, 12'h1F4 + 12'(sh[4]) * 12'h00A,
      md == 5'h1E && |(sh[5] & pins), md == 5'h1E};
  endfunction : exp_out
  initial forever #10 clk = ~clk;
  initial begin
    #20000 errors++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 chk("reset", {4'h0, 10'h000, 1'h1, 12'h000, 2'h0}, q);
    rstn = 1;
    tbl = 4'hA;
    @(posedge clk);
    #1 chk("idle", exp_out(), q);
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      a = i < 3 ? 8'h33 + 8'(i) : {5'h06, r[2:0]};
      d = i < 2 ? 8'hFF : i == 2 ? 8'h00 : r[15:8];
      sh[a[2:0]] = d & (a == 8'h33 ? 8'h8F : a == 8'h34 ? 8'h3F :
        a == 8'h35 ? 8'hFF : 8'h00);
      u_host.wr(a, d);
      {pins, adis, tbl} = r[28:16];
      md = r[29] || i == 2 ? 5'h1E : r[4:0];
      chk("rdata", 29'(sh[a[2:0]]), 29'(rd));
      @(posedge clk);
      #1 chk("peak", exp_out() >> 14, q >> 14);
      chk("pin", exp_out() << 15, q << 15);
    end
    test_done();
  end
endmodule : testbench
`default_nettype wire
